// >>> msi_pkg.sv
package msi_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int REG_ADDR_WIDTH = 5;
  localparam int REG_DATA_WIDTH = 24;
  localparam logic [4:0] STATUS_ADDR = 5'h0f;
  localparam logic [4:0] MASK_ADDR = 5'h1a;
  localparam logic [23:0] STATUS_RESET = 24'h80_0001;
  localparam logic [23:0] MASK_RESET = 24'h00_0000;
  // Status bits whose asserted state reads as zero
  localparam logic [23:0] STATUS_INVERT = 24'h00_0001;
  // Internal flag value at reset (asserted-high view of the status)
  localparam logic [23:0] FLAG_RESET = STATUS_RESET ^ STATUS_INVERT;

  // ------------------------------------------------------------
  // Status bit positions
  // ------------------------------------------------------------
  localparam int COMPUTATION_DONE_BIT = 23;
  localparam int CURRENT2_OVERFLOW_BIT = 22;
  localparam int VOLTAGE2_OVERFLOW_BIT = 21;
  localparam int CONVERSION_READY_BIT = 20;
  localparam int RMS_CURRENT2_OVERFLOW_BIT = 19;
  localparam int RMS_VOLTAGE2_OVERFLOW_BIT = 18;
  localparam int CURRENT_OVERFLOW_BIT = 17;
  localparam int VOLTAGE_OVERFLOW_BIT = 16;
  localparam int ENERGY2_OVERFLOW_BIT = 15;
  localparam int RMS_CURRENT_OVERFLOW_BIT = 14;
  localparam int RMS_VOLTAGE_OVERFLOW_BIT = 13;
  localparam int ENERGY_OVERFLOW_BIT = 12;
  localparam int CURRENT_FAULT_BIT = 11;
  localparam int VOLTAGE_DIP_BIT = 10;
  localparam int CURRENT2_FAULT_BIT = 9;
  localparam int VOLTAGE2_DIP_BIT = 8;
  localparam int TEMPERATURE_NEW_BIT = 7;
  localparam int VOLTAGE2_MODULATOR_OSC_BIT = 6;
  localparam int CURRENT2_MODULATOR_OSC_BIT = 5;
  localparam int VOLTAGE_MODULATOR_OSC_BIT = 4;
  localparam int CURRENT_MODULATOR_OSC_BIT = 3;
  localparam int LOW_SUPPLY_BIT = 2;
  localparam int EPSILON_NEW_BIT = 1;
  localparam int BAD_COMMAND_BIT = 0;

  // ------------------------------------------------------------
  // Detector channel order: current 1, voltage 1, current 2, voltage 2
  // ------------------------------------------------------------
  localparam int DIP_CHANNELS = 4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int IRQ_PULSE_NS = 1000;
  localparam int IRQ_PULSE_CYCLES =
    (IRQ_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // Pin behaviour, {irq_pulse_select, irq_polarity_select}
  typedef enum logic [1:0] {
    MSI_LEVEL_LOW,
    MSI_LEVEL_HIGH,
    MSI_PULSE_LOW,
    MSI_PULSE_HIGH
  } msi_irq_mode_type;

endpackage

// >>> msi_dip_detect.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Dip detector: one pulse when |sample| stays below level for more
// than half of duration samples
// ------------------------------------------------------------
module msi_dip_detect #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Samples
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample,
  // Thresholds
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] duration,
  // Event
  output logic detected
);

  logic [WIDTH-1:0] below_count;
  logic fired;
  logic [WIDTH-1:0] next_below_count;
  logic next_fired;
  logic next_detected;
  logic [WIDTH-1:0] magnitude;

  always_comb
  begin
    magnitude = sample[WIDTH-1] ? WIDTH'(-sample) : sample;
    next_below_count = below_count;
    next_fired = fired;
    next_detected = 1'b0;
    if (sample_valid)
    begin
      if (magnitude < level)
      begin
        if (below_count != {WIDTH{1'b1}})
        begin
          next_below_count = below_count + 1'b1;
        end
        // One event per dip
        if (!fired && (next_below_count > (duration >> 1)))
        begin
          next_detected = 1'b1;
          next_fired = 1'b1;
        end
      end
      else
      begin
        next_below_count = '0;
        next_fired = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      below_count <= '0;
      fired <= 1'b0;
      detected <= 1'b0;
    end
    else
    begin
      below_count <= next_below_count;
      fired <= next_fired;
      detected <= next_detected;
    end
  end

endmodule

// >>> msi_status_irq.sv
`timescale 1ns/1ns
module msi_status_irq #(
  parameter int WIDTH = msi_pkg::REG_DATA_WIDTH,
  parameter int PULSE_CYCLES = msi_pkg::IRQ_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port from the serial interface
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [4:0] reg_addr,
  input wire logic [WIDTH-1:0] reg_wdata,
  output logic [WIDTH-1:0] reg_rdata,
  output logic reg_rvalid,
  // Measurement engine events, one-cycle pulses
  input wire logic computation_done,
  input wire logic conversion_ready,
  input wire logic [3:0] instant_overflow,
  input wire logic [3:0] rms_overflow,
  input wire logic [1:0] energy_overflow,
  input wire logic temperature_ready,
  input wire logic epsilon_written,
  input wire logic bad_command,
  // Dip and fault detection samples, per channel
  input wire logic [3:0] dip_sample_valid,
  input wire logic [WIDTH-1:0] dip_sample [4],
  input wire logic [WIDTH-1:0] dip_level [4],
  input wire logic [WIDTH-1:0] dip_duration [4],
  // Asynchronous analog levels
  input wire logic [3:0] modulator_osc,
  input wire logic supply_below_low,
  input wire logic supply_above_high,
  // Pin configuration
  input wire logic irq_pulse_select,
  input wire logic irq_polarity_select,
  input wire logic irq_open_drain,
  // Interrupt pin
  output logic irq_out,
  output logic irq_oe_n
);

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [5:0] sync_first;
  logic [5:0] sync_second;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync_first <= '0;
      sync_second <= '0;
    end
    else
    begin
      sync_first <= {supply_above_high, supply_below_low, modulator_osc};
      sync_second <= sync_first;
    end
  end

  logic [3:0] osc_level;
  logic supply_low;
  logic supply_good;

  assign osc_level = sync_second[3:0];
  assign supply_low = sync_second[4];
  assign supply_good = sync_second[5];

  // ------------------------------------------------------------
  // Dip and fault detectors
  // ------------------------------------------------------------
  logic [3:0] dip_event;

  genvar ch;
  generate
    for (ch = 0; ch < msi_pkg::DIP_CHANNELS; ch++)
    begin : g_dip
      msi_dip_detect #(.WIDTH(WIDTH)) dip_detect (
        .clock(clock),
        .reset(reset),
        .sample_valid(dip_sample_valid[ch]),
        .sample(dip_sample[ch]),
        .level(dip_level[ch]),
        .duration(dip_duration[ch]),
        .detected(dip_event[ch])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Status flags (asserted-high view) and mask
  // ------------------------------------------------------------
  logic [WIDTH-1:0] flag;
  logic [WIDTH-1:0] mask;
  logic low_supply_hold;
  logic [WIDTH-1:0] next_flag;
  logic [WIDTH-1:0] next_mask;
  logic next_low_supply_hold;
  logic [WIDTH-1:0] set_vec;
  logic [WIDTH-1:0] clear_vec;
  logic write_status;
  logic write_mask;

  assign write_status = reg_write && (reg_addr == msi_pkg::STATUS_ADDR);
  assign write_mask = reg_write && (reg_addr == msi_pkg::MASK_ADDR);

  always_comb
  begin
    set_vec = '0;
    set_vec[msi_pkg::COMPUTATION_DONE_BIT] = computation_done;
    set_vec[msi_pkg::CONVERSION_READY_BIT] = conversion_ready;
    set_vec[msi_pkg::CURRENT_OVERFLOW_BIT] = instant_overflow[0];
    set_vec[msi_pkg::VOLTAGE_OVERFLOW_BIT] = instant_overflow[1];
    set_vec[msi_pkg::CURRENT2_OVERFLOW_BIT] = instant_overflow[2];
    set_vec[msi_pkg::VOLTAGE2_OVERFLOW_BIT] = instant_overflow[3];
    set_vec[msi_pkg::RMS_CURRENT_OVERFLOW_BIT] = rms_overflow[0];
    set_vec[msi_pkg::RMS_VOLTAGE_OVERFLOW_BIT] = rms_overflow[1];
    set_vec[msi_pkg::RMS_CURRENT2_OVERFLOW_BIT] = rms_overflow[2];
    set_vec[msi_pkg::RMS_VOLTAGE2_OVERFLOW_BIT] = rms_overflow[3];
    set_vec[msi_pkg::ENERGY_OVERFLOW_BIT] = energy_overflow[0];
    set_vec[msi_pkg::ENERGY2_OVERFLOW_BIT] = energy_overflow[1];
    set_vec[msi_pkg::CURRENT_FAULT_BIT] = dip_event[0];
    set_vec[msi_pkg::VOLTAGE_DIP_BIT] = dip_event[1];
    set_vec[msi_pkg::CURRENT2_FAULT_BIT] = dip_event[2];
    set_vec[msi_pkg::VOLTAGE2_DIP_BIT] = dip_event[3];
    set_vec[msi_pkg::TEMPERATURE_NEW_BIT] = temperature_ready;
    // Levels re-set the flag each cycle while overload lasts
    set_vec[msi_pkg::CURRENT_MODULATOR_OSC_BIT] = osc_level[0];
    set_vec[msi_pkg::VOLTAGE_MODULATOR_OSC_BIT] = osc_level[1];
    set_vec[msi_pkg::CURRENT2_MODULATOR_OSC_BIT] = osc_level[2];
    set_vec[msi_pkg::VOLTAGE2_MODULATOR_OSC_BIT] = osc_level[3];
    set_vec[msi_pkg::LOW_SUPPLY_BIT] = low_supply_hold;
    set_vec[msi_pkg::EPSILON_NEW_BIT] = epsilon_written;
    set_vec[msi_pkg::BAD_COMMAND_BIT] = bad_command;

    clear_vec = write_status ? reg_wdata : '0;
    // A set in the same cycle as its clear wins
    next_flag = (flag & ~clear_vec) | set_vec;
    next_mask = write_mask ? reg_wdata : mask;

    // Low supply latch releases only above the high threshold
    next_low_supply_hold = low_supply_hold;
    if (supply_low)
    begin
      next_low_supply_hold = 1'b1;
    end
    else if (supply_good)
    begin
      next_low_supply_hold = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      flag <= msi_pkg::FLAG_RESET;
      mask <= msi_pkg::MASK_RESET;
      low_supply_hold <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
      mask <= next_mask;
      low_supply_hold <= next_low_supply_hold;
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  logic [WIDTH-1:0] next_rdata;

  always_comb
  begin
    case (reg_addr)
      msi_pkg::STATUS_ADDR:
      begin
        next_rdata = flag ^ msi_pkg::STATUS_INVERT;
      end
      msi_pkg::MASK_ADDR: next_rdata = mask;
      default: next_rdata = '0;
    endcase
    if (!reg_read)
    begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_rdata;
      reg_rvalid <= reg_read;
    end
  end

  // ------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------
  msi_pkg::msi_irq_mode_type irq_mode;
  logic pending;
  logic pending_last;
  logic [15:0] pulse_count;
  logic irq_active;
  logic next_pending_last;
  logic [15:0] next_pulse_count;
  logic next_irq_out;
  logic next_irq_active;

  assign irq_mode =
    msi_pkg::msi_irq_mode_type'({irq_pulse_select, irq_polarity_select});
  assign pending = |(flag & mask);

  always_comb
  begin
    next_pending_last = pending;
    next_pulse_count = pulse_count;
    case (irq_mode)
      msi_pkg::MSI_LEVEL_LOW,
      msi_pkg::MSI_LEVEL_HIGH:
      begin
        next_pulse_count = '0;
        next_irq_active = pending;
      end
      msi_pkg::MSI_PULSE_LOW,
      msi_pkg::MSI_PULSE_HIGH:
      begin
        // A fixed-width pulse on each new pending condition
        if (pending && !pending_last)
        begin
          next_pulse_count = 16'(PULSE_CYCLES);
        end
        else if (pulse_count != '0)
        begin
          next_pulse_count = pulse_count - 1'b1;
        end
        next_irq_active = next_pulse_count != '0;
      end
      default: next_irq_active = 1'b0;
    endcase
    // Active level follows the polarity bit
    next_irq_out = next_irq_active == irq_polarity_select;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pending_last <= 1'b0;
      pulse_count <= '0;
      irq_active <= 1'b0;
      irq_out <= 1'b1;
    end
    else
    begin
      pending_last <= next_pending_last;
      pulse_count <= next_pulse_count;
      irq_active <= next_irq_active;
      irq_out <= next_irq_out;
    end
  end

  // Open drain releases the pin whenever it would drive high
  assign irq_oe_n = irq_open_drain && irq_out;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_w1c_clears;
    @(posedge clock) disable iff (reset)
    write_status |=>
      ((flag & $past(reg_wdata) & ~$past(set_vec)) == '0);
  endproperty
  a_w1c_clears: assert property (p_w1c_clears)
    else $error("status bit not cleared by write of one");

  property p_zero_keeps;
    @(posedge clock) disable iff (reset)
    write_status |=>
      ((flag & ~$past(reg_wdata)) == (($past(flag) | $past(set_vec))
        & ~$past(reg_wdata)));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("status bit changed by write of zero");

  property p_set_wins;
    @(posedge clock) disable iff (reset)
    (set_vec != '0) |=> ((flag & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in status register");

  property p_mask_write;
    @(posedge clock) disable iff (reset)
    write_mask ##1 !write_mask
      ##1 (reg_read && (reg_addr == msi_pkg::MASK_ADDR))
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask readback differs from written value");

  property p_level_irq;
    @(posedge clock) disable iff (reset)
    (!irq_pulse_select && pending)[*2] |->
      irq_out == $past(irq_polarity_select);
  endproperty
  a_level_irq: assert property (p_level_irq)
    else $error("level interrupt not active while pending");

  property p_level_release;
    @(posedge clock) disable iff (reset)
    (!irq_pulse_select && !pending)[*2] |->
      irq_out != $past(irq_polarity_select);
  endproperty
  a_level_release: assert property (p_level_release)
    else $error("level interrupt active with nothing pending");

  property p_pulse_len;
    @(posedge clock) disable iff (reset)
    $rose(irq_active) && irq_pulse_select |->
      pulse_count == 16'(PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("interrupt pulse started with wrong length");

  property p_open_drain;
    @(posedge clock) disable iff (reset)
    irq_open_drain && irq_out |-> irq_oe_n;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_bad_command;
    @(posedge clock) disable iff (reset)
    bad_command ##1 !write_status
      ##1 (reg_read && (reg_addr == msi_pkg::STATUS_ADDR))
      |=> !reg_rdata[msi_pkg::BAD_COMMAND_BIT];
  endproperty
  a_bad_command: assert property (p_bad_command)
    else $error("invalid command not shown as zero");

  property p_supply_hold;
    @(posedge clock) disable iff (reset)
    low_supply_hold |=> flag[msi_pkg::LOW_SUPPLY_BIT];
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("low supply flag cleared before recovery");

  c_clear_and_set: cover property (@(posedge clock) disable iff (reset)
    write_status && ((reg_wdata & set_vec) != '0));
  c_level_irq: cover property (@(posedge clock) disable iff (reset)
    !irq_pulse_select && $rose(pending));
  c_pulse_irq: cover property (@(posedge clock) disable iff (reset)
    irq_pulse_select && $fell(irq_active));
  c_dip: cover property (@(posedge clock) disable iff (reset)
    dip_event != '0);

endmodule

// >>> msi_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module msi_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_write,
  output logic reg_read,
  output logic [4:0] reg_addr,
  output logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h00_0000;
  end

  // Strobes last one cycle; address and data are scrambled afterwards
  task automatic write_reg(input logic [4:0] a, input logic [23:0] d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [23:0] d,
                          output logic ok);
    int i;
    ok = 1'b0;
    d = 24'h00_0000;
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_read = 1'b0;
    reg_addr = ~a;
    for (i = 0; i < 4 && !ok; i++)
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata;
      end
      else
        @(negedge clock);
  endtask
endmodule

// >>> measurement_status_irq_bench.sv
`timescale 1ns/1ns
module measurement_status_irq_bench;
  logic clock;
  logic reset;
  logic reg_write, reg_read, reg_rvalid;
  logic [4:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic [14:0] ev;
  logic [3:0] dv, osc;
  logic [23:0] ds [4];
  logic [23:0] dl [4];
  logic [23:0] dd [4];
  logic lo, hi, psel, pol, od, irq_out, irq_oe_n;
  int n_errors = 0;
  int cmp_count = 0;
  int evb [15] = '{23, 20, 17, 16, 22, 21, 14, 13, 19, 18, 12, 15, 7, 1, 0};
  int dipb [4] = '{11, 10, 9, 8};

  msi_status_irq #(.PULSE_CYCLES(4)) i_msi_status_irq (
    .clock(clock), .reset(reset),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .computation_done(ev[0]), .conversion_ready(ev[1]),
    .instant_overflow(ev[5:2]), .rms_overflow(ev[9:6]),
    .energy_overflow(ev[11:10]), .temperature_ready(ev[12]),
    .epsilon_written(ev[13]), .bad_command(ev[14]),
    .dip_sample_valid(dv), .dip_sample(ds), .dip_level(dl),
    .dip_duration(dd), .modulator_osc(osc),
    .supply_below_low(lo), .supply_above_high(hi),
    .irq_pulse_select(psel), .irq_polarity_select(pol),
    .irq_open_drain(od), .irq_out(irq_out), .irq_oe_n(irq_oe_n)
  );

  msi_host_model i_msi_host_model (
    .clock(clock), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task results;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input string n, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask

  task rd(input string n, input logic [4:0] a, input logic [23:0] e);
    logic [23:0] d;
    logic ok;
    i_msi_host_model.read_reg(a, d, ok);
    if (ok !== 1'b1)
    begin
      $display("[FAIL] %s expected rvalid seen none", n);
      n_errors++;
      results();
    end
    check(n, e, d);
  endtask

  task wr(input logic [4:0] a, input logic [23:0] d);
    i_msi_host_model.write_reg(a, d);
  endtask

  task pulse(input int i);
    @(negedge clock);
    ev[i] = 1'b1;
    @(negedge clock);
    ev = '0;
  endtask

  task samp(input int c, input logic [23:0] v);
    @(negedge clock);
    dv[c] = 1'b1;
    ds[c] = v;
    @(negedge clock);
    dv[c] = 1'b0;
    ds[c] = ~v;
  endtask

  // Mask bit 7 must be set before this runs
  task irq_mode(input logic [1:0] m);
    int c;
    logic act;
    act = m[0];
    psel = m[1];
    pol = m[0];
    repeat (4) @(negedge clock);
    check("irq_idle", {23'h00_0000, ~act}, {23'h00_0000, irq_out});
    pulse(12);
    c = 0;
    repeat (20)
    begin
      @(negedge clock);
      if (irq_out === act)
        c++;
    end
    check("irq_on", m[1] ? 24'h00_0004 : 24'h00_0014, c[23:0]);
    check("oe_normal", 24'h00_0000, {23'h00_0000, irq_oe_n});
    wr(5'h0f, 24'h00_0080);
    repeat (3) @(negedge clock);
    check("irq_off", {23'h00_0000, ~act}, {23'h00_0000, irq_out});
  endtask

  initial
  begin
    logic [23:0] e;
    reset = 1'b1;
    ev = '0;
    dv = '0;
    osc = '0;
    lo = 1'b0;
    hi = 1'b0;
    psel = 1'b0;
    pol = 1'b0;
    od = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      ds[i] = 24'h00_0000;
      dl[i] = 24'h00_0064;
      dd[i] = 24'h00_0008;
    end
    repeat (8) @(negedge clock);
    reset = 1'b0;
    rd("status_rst", 5'h0f, 24'h80_0001);
    rd("mask_rst", 5'h1a, 24'h00_0000);
    rd("unmapped", 5'h10, 24'h00_0000);
    check("irq_rst", 24'h00_0001, {23'h00_0000, irq_out});
    wr(5'h0f, 24'h00_0000);
    rd("keep", 5'h0f, 24'h80_0001);
    wr(5'h0f, 24'h80_0000);
    rd("clear", 5'h0f, 24'h00_0001);
    // Every engine event sets its own bit only
    for (int i = 0; i < 15; i++)
    begin
      pulse(i);
      e = 24'h00_0001 ^ (24'h00_0001 << evb[i]);
      rd("ev", 5'h0f, e);
      wr(5'h0f, 24'h00_0001 << evb[i]);
      rd("ev_clr", 5'h0f, 24'h00_0001);
    end
    wr(5'h1a, 24'h00_0080);
    rd("mask", 5'h1a, 24'h00_0080);
    for (int m = 0; m < 4; m++)
      irq_mode(m[1:0]);
    psel = 1'b0;
    pol = 1'b0;
    od = 1'b1;
    pulse(12);
    repeat (2) @(negedge clock);
    check("od_drive", 24'h00_0000, {23'h00_0000, irq_oe_n});
    wr(5'h0f, 24'h00_0080);
    repeat (3) @(negedge clock);
    check("od_free", 24'h00_0001, {23'h00_0000, irq_oe_n});
    od = 1'b0;
    wr(5'h1a, 24'h00_0000);
    pulse(12);
    repeat (4) @(negedge clock);
    check("masked", 24'h00_0001, {23'h00_0000, irq_out});
    wr(5'h0f, 24'h00_0080);
    // Oscillation keeps re-setting its flag while present
    for (int c = 0; c < 4; c++)
    begin
      e = 24'h00_0001 | (24'h00_0008 << c);
      osc[c] = 1'b1;
      repeat (4) @(negedge clock);
      rd("osc", 5'h0f, e);
      wr(5'h0f, e ^ 24'h00_0001);
      rd("osc_again", 5'h0f, e);
      osc[c] = 1'b0;
      repeat (4) @(negedge clock);
      wr(5'h0f, e ^ 24'h00_0001);
      rd("osc_clr", 5'h0f, 24'h00_0001);
    end
    lo = 1'b1;
    repeat (4) @(negedge clock);
    lo = 1'b0;
    repeat (4) @(negedge clock);
    wr(5'h0f, 24'h00_0004);
    rd("low_held", 5'h0f, 24'h00_0005);
    hi = 1'b1;
    repeat (4) @(negedge clock);
    wr(5'h0f, 24'h00_0004);
    rd("low_clr", 5'h0f, 24'h00_0001);
    // Duration 8: the fifth low sample is the first past half
    for (int c = 0; c < 4; c++)
    begin
      repeat (4) samp(c, 24'hff_fff6);
      rd("dip_wait", 5'h0f, 24'h00_0001);
      samp(c, 24'h00_000a);
      repeat (2) @(negedge clock);
      e = 24'h00_0001 | (24'h00_0001 << dipb[c]);
      rd("dip", 5'h0f, e);
      wr(5'h0f, e ^ 24'h00_0001);
    end
    results();
  end
endmodule
